// ### rtl/igd_defs.vh
// constants for the isolated gate driver control block
`ifndef IGD_DEFS_VH
`define IGD_DEFS_VH

// ************************************************************
// clock and filter timing
// ************************************************************
`define IGD_CLK_PERIOD_NS 10
`define IGD_DEGLITCH_NS 40
`define IGD_DEGLITCH_CYC ((`IGD_DEGLITCH_NS + `IGD_CLK_PERIOD_NS - 1) / `IGD_CLK_PERIOD_NS)
`define IGD_MUTE_CYC_DEF 1000
`define IGD_RSTFIL_CYC_DEF 100
`define IGD_TWO_LEVEL_CYC_DEF 50
`define IGD_SENSOR_FREQ_KHZ 400
`define IGD_SENSOR_PERIOD_CYC (100000 / `IGD_SENSOR_FREQ_KHZ)
`define IGD_DUTY_MIN_PCT 10
`define IGD_DUTY_MAX_PCT 88

// ************************************************************
// apb register map
// ************************************************************
`define IGD_ADDR_CTRL 12'h000
`define IGD_ADDR_STATUS 12'h004
`define IGD_ADDR_SENSE 12'h008
`define IGD_CTRL_RESET 32'h00000000
`define IGD_SENSE_RESET 8'hff

// status bit positions
`define IGD_ST_FAULT 0
`define IGD_ST_MUTE 1
`define IGD_ST_UNDERVOLTAGE_LOCKOUT 2
`define IGD_ST_EN 3
`define IGD_ST_GATE 4
`define IGD_ST_TWO_LEVEL 5

`endif

// ### rtl/igd_gate_ctrl.v
// control logic of the isolated single channel gate driver
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "igd_defs.vh"

// What this block does
// - supply up/down levels come from comparators
// - input up, output supply down: lockout outputs
// - input supply down: gate low, clamp high
// - disabled: gate low, clamp high, ready released
// - inverting input high keeps gate off
// - reject pulses shorter than 40 ns
// - fault: two-level turn-off, fault pin low
// - fault stays latched until valid reset
// - lockout pulls gate down, recovers automatically
// - reset pin high enables, low disables
// - reset ignored during fault mute time
// - long low then rising edge clears fault
// - floating reset pin means disabled
// - sensor pwm duty 10 to 88 percent
module igd_gate_ctrl #(
   parameter MUTE_CYC = `IGD_MUTE_CYC_DEF,
   parameter RSTFIL_CYC = `IGD_RSTFIL_CYC_DEF,
   parameter TWO_LEVEL_CYC = `IGD_TWO_LEVEL_CYC_DEF
) (
   input wire core_clk, // 100 mhz clock
   input wire nrst, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   input wire noninv_pwm_in, // noninverting pwm pin
   input wire inv_pwm_in, // inverting pwm pin
   input wire reset_enable_n, // reset/enable pin, pulled down
   input wire input_supply_up, // input supply comparator
   input wire pos_supply_up, // positive output supply comparator
   input wire pos_supply_open, // positive supply pin open
   input wire neg_supply_up, // negative output supply comparator
   input wire overcurrent_in, // overcurrent comparator
   output reg gate_drive_out, // gate drive level
   output reg gate_drive_oe, // gate drive enable
   output reg gate_two_level, // mid-level turn-off active
   output reg clamp_drive_out, // miller clamp level
   output reg clamp_drive_oe, // miller clamp enable
   output reg sensor_pwm_out, // sensor pwm level
   output reg sensor_pwm_oe, // sensor pwm enable
   output reg supply_good_out, // ready open drain level (0)
   output reg supply_good_oe, // ready pulls low when high
   output reg fault_n_out, // fault open drain level (0)
   output reg fault_n_oe // fault pulls low when high
);

   // ************************************************************
   // input synchronisers and deglitch filters
   // ************************************************************
   // supply comparators pass the same filter as the pins, so a
   // brief dip on a rail never toggles the lockout outputs
   localparam NIN = 8;
   localparam integer DG_CYC_I = `IGD_DEGLITCH_CYC;
   // 40 ns at 10 ns per cycle: four equal samples before a change
   localparam [7:0] DG_CYC = DG_CYC_I[7:0];
   wire [NIN-1:0] raw_in;
   reg [NIN-1:0] sync1;
   reg [NIN-1:0] sync2;
   reg [NIN-1:0] filt;
   assign raw_in = {overcurrent_in, neg_supply_up, pos_supply_open, pos_supply_up,
                    input_supply_up, reset_enable_n, inv_pwm_in, noninv_pwm_in};

   // two flops on every pin
   // the first stage may go metastable; only the second stage is read
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   // each input changes only after DG_CYC stable samples
   // a level shorter than that resets the count and is lost
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1) begin : g_dg
         reg [7:0] cnt;
         always @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               cnt <= 8'h00;
               filt[gi] <= 1'b0;
            end else if (sync2[gi] == filt[gi]) begin
               cnt <= 8'h00;
            end else if (cnt >= DG_CYC - 8'h01) begin
               cnt <= 8'h00;
               filt[gi] <= sync2[gi];
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   endgenerate

   // filtered levels, in the bit order of raw_in
   // every decision below reads these, never the raw pins
   wire f_pos = filt[0];
   wire f_neg = filt[1];
   wire f_en = filt[2]; // (reset value low: disabled)
   wire s_vcc = filt[3];
   wire s_vdd = filt[4];
   wire s_open = filt[5];
   wire s_vee = filt[6];
   wire f_oc = filt[7];

   // ************************************************************
   // registers written by software
   // ************************************************************
   // ctrl bit0 holds the gate off without touching the fault logic
   reg [31:0] ctrl; // bit0 software gate inhibit
   reg [7:0] sense_code; // sensed voltage code, ff = 4.5 V or open

   // ************************************************************
   // fault latch, mute timer and reset filter
   // ************************************************************
   // the latch is set only while the gate is high, as the current
   // sense is blinded while the switch is off; during the mute time
   // the reset pin is ignored, and afterwards it must stay low for
   // RSTFIL_CYC filtered cycles before a rising edge clears the latch
   reg fault;
   reg [15:0] mute_cnt;
   reg [15:0] low_cnt;
   reg reset_armed;
   reg en_d;
   reg [15:0] tl_cnt;
   // the gate may rise only with every rail good, enabled, no latch,
   // the own pwm high, the other leg low and no software inhibit
   wire supplies_ok = s_vcc && s_vdd && !s_open && s_vee;
   wire gate_on_req = supplies_ok && f_en && !fault && f_pos && !f_neg && !ctrl[0];
   wire en_rise = f_en && !en_d;

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fault <= 1'b0;
         mute_cnt <= 16'h0000;
         low_cnt <= 16'h0000;
         reset_armed <= 1'b0;
         en_d <= 1'b0;
         tl_cnt <= 16'h0000;
      end else begin
         en_d <= f_en;
         // count the low time of the reset pin while the mute has expired
         if (f_en || mute_cnt != 16'h0000) begin
            low_cnt <= 16'h0000;
         end else if (low_cnt < RSTFIL_CYC[15:0]) begin
            low_cnt <= low_cnt + 16'h0001;
         end
         if (fault && !f_en && mute_cnt == 16'h0000 && low_cnt >= RSTFIL_CYC[15:0]) begin
            reset_armed <= 1'b1;
         end
         // mute and two-level timers count down to zero and stop
         if (mute_cnt != 16'h0000) begin
            mute_cnt <= mute_cnt - 16'h0001;
         end
         if (tl_cnt != 16'h0000) begin
            tl_cnt <= tl_cnt - 16'h0001;
         end
         // an overcurrent in the same cycle as a clear is ignored, as the latch is still set
         if (f_oc && gate_drive_out && !fault) begin
            fault <= 1'b1;
            mute_cnt <= MUTE_CYC[15:0];
            tl_cnt <= TWO_LEVEL_CYC[15:0];
            reset_armed <= 1'b0;
         end else if (fault && reset_armed && en_rise) begin
            fault <= 1'b0;
            reset_armed <= 1'b0;
         end
      end
   end

   // ************************************************************
   // sensor pwm: 400 khz, duty from 10 to 88 percent
   // ************************************************************
   // the sensed code stands in for the analog conversion, which lies
   // outside this block; integer division rounds the high time down
   localparam integer SP_PER_I = `IGD_SENSOR_PERIOD_CYC;
   localparam integer DMIN_I = `IGD_DUTY_MIN_PCT;
   localparam integer DMAX_I = `IGD_DUTY_MAX_PCT;
   localparam [7:0] SP_PER = SP_PER_I[7:0];
   localparam [15:0] DMIN = DMIN_I[15:0];
   localparam [15:0] DMAX = DMAX_I[15:0];
   reg [7:0] sp_cnt;
   reg [15:0] duty_pct;
   reg [15:0] hi_cyc;
   always @* begin
      // lower code means lower voltage and higher duty
      duty_pct = DMAX - (((DMAX - DMIN) * {8'h00, sense_code}) / 16'h00ff);
      hi_cyc = (duty_pct * {8'h00, SP_PER}) / 16'h0064; // percent to cycles
   end
   // free running period counter
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sp_cnt <= 8'h00;
      end else if (sp_cnt >= SP_PER - 8'h01) begin
         sp_cnt <= 8'h00;
      end else begin
         sp_cnt <= sp_cnt + 8'h01;
      end
   end
   wire sp_level = ({8'h00, sp_cnt} < hi_cyc);

   // ************************************************************
   // output decode from supply state, enable and inputs
   // ************************************************************
   // priority: open positive rail, positive rail down, input side down,
   // negative rail down, then disabled; only a fully powered and enabled
   // driver may switch the gate, and there the clamp is the gate's complement
   reg next_gate;
   reg next_gate_oe;
   reg next_clamp;
   reg next_clamp_oe;
   reg next_sp;
   reg next_sp_oe;
   reg next_rdy_oe;
   always @* begin
      next_gate = 1'b0;
      next_gate_oe = 1'b1;
      next_clamp = 1'b1;
      next_clamp_oe = 1'b1;
      next_sp = 1'b0;
      next_sp_oe = 1'b1;
      next_rdy_oe = 1'b0;
      if (s_vcc && s_open) begin
         next_rdy_oe = 1'b1;
         next_gate_oe = 1'b0;
         next_clamp_oe = 1'b0;
         next_sp_oe = 1'b0;
      end else if (s_vcc && !s_vdd) begin
         next_rdy_oe = 1'b1;
         next_clamp = 1'b0;
      end else if (!s_vcc) begin
         next_clamp = 1'b1;
      end else if (!s_vee) begin
         next_rdy_oe = 1'b1;
      end else if (!f_en) begin
         next_clamp = 1'b1;
      end else begin
         next_sp = sp_level;
         next_gate = gate_on_req;
         next_clamp = !gate_on_req;
      end
   end

   // all pin outputs from flops
   // the extra cycle keeps decode glitches off the pins
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         gate_drive_out <= 1'b0;
         gate_drive_oe <= 1'b1;
         gate_two_level <= 1'b0;
         clamp_drive_out <= 1'b1;
         clamp_drive_oe <= 1'b1;
         sensor_pwm_out <= 1'b0;
         sensor_pwm_oe <= 1'b1;
         supply_good_out <= 1'b0;
         supply_good_oe <= 1'b1;
         fault_n_out <= 1'b0;
         fault_n_oe <= 1'b0;
      end else begin
         gate_drive_out <= next_gate;
         gate_drive_oe <= next_gate_oe;
         gate_two_level <= fault && tl_cnt != 16'h0000;
         clamp_drive_out <= next_clamp;
         clamp_drive_oe <= next_clamp_oe;
         sensor_pwm_out <= next_sp;
         sensor_pwm_oe <= next_sp_oe;
         supply_good_oe <= next_rdy_oe;
         fault_n_oe <= fault;
      end
   end

   // ************************************************************
   // apb slave, zero wait states
   // ************************************************************
   // status bits: fault, mute, ready low, enable, gate, two-level
   wire [31:0] status = {26'h0, gate_two_level, gate_drive_out, f_en,
                         supply_good_oe, mute_cnt != 16'h0000, fault};
   wire acc = psel && penable;
   // map a byte address onto a register slot, 3 for unmapped
   // shared by the error flag, the read mux and the write decode
   function [1:0] reg_slot;
      input [11:0] a;
      begin
         case (a)
            `IGD_ADDR_CTRL: reg_slot = 2'h0;
            `IGD_ADDR_STATUS: reg_slot = 2'h1;
            `IGD_ADDR_SENSE: reg_slot = 2'h2;
            default: reg_slot = 2'h3;
         endcase
      end
   endfunction
   wire [1:0] slot = reg_slot(paddr);
   wire known = (slot != 2'h3);
   // pready answers the setup cycle, so each access lasts one cycle;
   // a write lands at the edge that samples pready high
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= `IGD_CTRL_RESET;
         sense_code <= `IGD_SENSE_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
         prdata <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            case (slot)
               2'h0: prdata <= ctrl;
               2'h1: prdata <= status;
               2'h2: prdata <= {24'h0, sense_code};
               default: prdata <= 32'h00000000;
            endcase
         end
         if (acc && pready && pwrite) begin
            case (slot)
               2'h0: ctrl <= {31'h0, pwdata[0]};
               2'h2: sense_code <= pwdata[7:0];
               default: ctrl <= ctrl;
            endcase
         end
      end
   end

endmodule

// ### verification/igd_host_model.sv
// host model driving the pwm and reset/enable pins
`timescale 1ns/10ps
module igd_host_model (
   input wire core_clk, // clock
   output logic noninv_pwm_in = 1'b0, // own pwm, never floating
   output logic inv_pwm_in = 1'b0, // other leg pwm, grounded when idle
   output logic reset_enable_n = 1'b0 // high enables, low resets
);
   // set the pins after an edge and hold them for a number of edges
   task automatic pins(input logic own, input logic other, input logic en, input int hold);
      @(posedge core_clk);
      noninv_pwm_in <= own;
      inv_pwm_in <= other;
      reset_enable_n <= en;
      repeat (hold - 1) @(posedge core_clk);
   endtask
endmodule

// ### verification/igd_gate_ctrl_properties.sv
// concurrent checks on the gate driver control ports
`timescale 1ns/10ps
module igd_props (
   input wire core_clk, // clock
   input wire nrst, // async reset
   input wire noninv_pwm_in, // pwm pin
   input wire inv_pwm_in, // inverting pin
   input wire reset_enable_n, // enable pin
   input wire input_supply_up, // input supply
   input wire pos_supply_up, // positive supply
   input wire pos_supply_open, // positive pin open
   input wire neg_supply_up, // negative supply
   input wire gate_drive_out, // gate level
   input wire gate_drive_oe, // gate enable
   input wire gate_two_level, // mid-level off
   input wire clamp_drive_out, // clamp level
   input wire clamp_drive_oe, // clamp enable
   input wire sensor_pwm_oe, // sensor enable
   input wire supply_good_oe, // ready pulled low
   input wire fault_n_oe // fault pulled low
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // supply states as the comparators report them
   wire pos_down = input_supply_up && !pos_supply_up && !pos_supply_open;
   wire off_pin = !reset_enable_n && input_supply_up && pos_supply_up && !pos_supply_open && neg_supply_up;
   // a level held ten cycles has passed the pin filter and the output stage
   sequence s_held(c);
      c[*8] ##1 c[*2];
   endsequence
   property p_on_clamp; gate_drive_out && gate_drive_oe |-> !clamp_drive_out; endproperty
   property p_inv_off; s_held(inv_pwm_in) |-> !gate_drive_out; endproperty
   property p_noninv_off; s_held(!noninv_pwm_in) |-> !gate_drive_out; endproperty
   property p_disabled; s_held(off_pin) |-> !gate_drive_out && clamp_drive_out && !supply_good_oe; endproperty
   property p_pos_open; s_held(pos_supply_open) |-> supply_good_oe && !gate_drive_oe && !sensor_pwm_oe; endproperty
   property p_pos_down; s_held(pos_down) |-> supply_good_oe && !gate_drive_out; endproperty
   property p_fault_off; $rose(fault_n_oe) |-> ##[0:2] (gate_two_level && !gate_drive_out); endproperty
   property p_latched; reset_enable_n[*8] ##1 reset_enable_n[*3] ##0 fault_n_oe |=> fault_n_oe; endproperty
   a_on_clamp: assert property (p_on_clamp) else $error("gate on with clamp on");
   a_inv_off: assert property (p_inv_off) else $error("gate on with inverting high");
   a_noninv_off: assert property (p_noninv_off) else $error("gate on with pwm low");
   a_disabled: assert property (p_disabled) else $error("disabled outputs wrong");
   a_pos_open: assert property (p_pos_open) else $error("open supply outputs driven");
   a_pos_down: assert property (p_pos_down) else $error("lockout outputs wrong");
   a_fault_off: assert property (p_fault_off) else $error("fault without two-level off");
   a_latched: assert property (p_latched) else $error("fault released without reset");
   c_fault: cover property ($rose(fault_n_oe));
   c_gate_on: cover property (gate_drive_out);
   c_open: cover property (pos_supply_open && !gate_drive_oe);
endmodule
bind igd_gate_ctrl igd_props props_u (.core_clk, .nrst, .noninv_pwm_in, .inv_pwm_in, .reset_enable_n,
   .input_supply_up, .pos_supply_up, .pos_supply_open, .neg_supply_up, .gate_drive_out, .gate_drive_oe,
   .gate_two_level, .clamp_drive_out, .clamp_drive_oe, .sensor_pwm_oe, .supply_good_oe, .fault_n_oe);

// ### verification/testbench.sv
// self-checking bench for the gate driver control block
`timescale 1ns/10ps
module testbench;
   logic core_clk = 0;
   logic nrst = 0;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, er;
   logic input_supply_up = 1, pos_supply_up = 1, pos_supply_open = 0, neg_supply_up = 1, overcurrent_in = 0;
   logic gate_drive_out, gate_drive_oe, gate_two_level, clamp_drive_out, clamp_drive_oe, sensor_pwm_out;
   logic sensor_pwm_oe, supply_good_out, supply_good_oe, fault_n_out, fault_n_oe;
   wire noninv_pwm_in, inv_pwm_in, reset_enable_n;
   int failures = 0, samples_checked = 0, low_cnt = 0, hi_cnt = 0, n;
   // supply cases {input, positive, open, negative} with expected port pattern and mask
   logic [3:0] sup [4] = '{4'h9, 4'h5, 4'hf, 4'hc};
   logic [7:0] exp_v [4] = '{8'haa, 8'hb8, 8'h02, 8'hba};
   logic [7:0] msk [4] = '{8'hff, 8'hff, 8'hab, 8'hff};
   igd_gate_ctrl #(.MUTE_CYC(20), .RSTFIL_CYC(5), .TWO_LEVEL_CYC(5)) dut_u (.core_clk, .nrst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .noninv_pwm_in, .inv_pwm_in, .reset_enable_n,
      .input_supply_up, .pos_supply_up, .pos_supply_open, .neg_supply_up, .overcurrent_in, .gate_drive_out,
      .gate_drive_oe, .gate_two_level, .clamp_drive_out, .clamp_drive_oe, .sensor_pwm_out, .sensor_pwm_oe,
      .supply_good_out, .supply_good_oe, .fault_n_out, .fault_n_oe);
   igd_host_model host_u (.core_clk, .noninv_pwm_in, .inv_pwm_in, .reset_enable_n);
   always #5 core_clk = ~core_clk;
   // count gate-low and sensor-high cycles
   always @(posedge core_clk) begin
      low_cnt <= low_cnt + (gate_drive_out !== 1'b1);
      hi_cnt <= hi_cnt + (sensor_pwm_out === 1'b1);
   end
   function automatic logic [7:0] obs();
      return {gate_drive_oe, gate_drive_out, clamp_drive_oe, clamp_drive_out, sensor_pwm_oe, sensor_pwm_out,
         supply_good_oe, fault_n_oe};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one apb transfer held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (k >= 20) begin
         failures++;
         tally_and_finish();
      end
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1;
      host_u.pins(0, 0, 0, 12);
      check(obs(), 8'hb8);
      apb(0, 12'h000, 0);
      check(rd, 0);
      apb(0, 12'h008, 0);
      check(rd, 32'hff);
      apb(0, 12'h00c, 0);
      check({rd[30:0], er}, 1);
      host_u.pins(1, 0, 1, 12);
      check({gate_drive_out, clamp_drive_out}, 2'b10);
      n = low_cnt;
      host_u.pins(1, 1, 1, 3);
      host_u.pins(1, 0, 1, 12);
      host_u.pins(0, 0, 1, 3);
      host_u.pins(1, 0, 1, 12);
      host_u.pins(1, 0, 0, 3);
      host_u.pins(1, 0, 1, 12);
      check(low_cnt - n, 0);
      host_u.pins(1, 1, 1, 12);
      check({gate_drive_out, clamp_drive_out}, 2'b01);
      host_u.pins(0, 0, 1, 12);
      check({gate_drive_out, clamp_drive_out}, 2'b01);
      n = hi_cnt;
      repeat (250) @(posedge core_clk);
      check(hi_cnt - n, 25);
      apb(1, 12'h008, 0);
      repeat (300) @(posedge core_clk);
      n = hi_cnt;
      repeat (250) @(posedge core_clk);
      check(hi_cnt - n, 220);
      host_u.pins(1, 0, 1, 12);
      overcurrent_in <= 1;
      n = 0;
      while (fault_n_oe !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      overcurrent_in <= 0;
      @(posedge core_clk);
      check({n < 20, gate_two_level, gate_drive_out}, 3'b110);
      host_u.pins(1, 0, 0, 8);
      host_u.pins(1, 0, 1, 12);
      check({fault_n_oe, gate_drive_out}, 2'b10);
      host_u.pins(1, 0, 0, 12);
      check(fault_n_oe, 1);
      host_u.pins(1, 0, 1, 12);
      check({fault_n_oe, gate_drive_out}, 2'b01);
      for (int i = 0; i < 4; i++) begin
         {input_supply_up, pos_supply_up, pos_supply_open, neg_supply_up} <= sup[i];
         repeat (12) @(posedge core_clk);
         check(obs() & msk[i], exp_v[i]);
      end
      {input_supply_up, pos_supply_up, pos_supply_open, neg_supply_up} <= 4'hd;
      repeat (12) @(posedge core_clk);
      check(gate_drive_out, 1);
      apb(1, 12'h000, 1);
      repeat (3) @(posedge core_clk);
      check({gate_drive_out, clamp_drive_out}, 2'b01);
      apb(0, 12'h000, 0);
      check(rd, 1);
      apb(0, 12'h004, 0);
      check(rd, 32'h00000008);
      apb(1, 12'h00c, 5);
      check(er, 1);
      apb(1, 12'h000, 0);
      repeat (3) @(posedge core_clk);
      check({gate_drive_out, supply_good_out, fault_n_out}, 3'b100);
      tally_and_finish();
   end
endmodule
